// ### logic/sesc_pkg.sv
// package: pin groups, control word layout and timing constants for the scrub controller
package sesc_pkg;
  // ********************************************************
  // clock and timing
  // ********************************************************
  localparam int CLK_PERIOD_NS      = 10;
  localparam int T_SETUP_NS         = 20;   // address/enable setup before error flag strobe
  localparam int T_FLAG_HIGH_NS     = 20;   // error flag high pulse, covers 12.8 ns minimum
  localparam int T_DATA_VALID_NS    = 10;   // covers 8.2 ns flag-high-to-data-valid
  localparam int T_RELEASE_NS       = 20;   // error flag low to enable release, covers 20 ns
  localparam int SETUP_CYC   = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAGH_CYC   = (T_FLAG_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DVALID_CYC  = (T_DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC = (T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W     = 4;

  // ********************************************************
  // control word layout, carried on address bits
  // ********************************************************
  localparam int RATE_LSB    = 0;
  localparam int DELAY_LSB   = 4;
  localparam int BYPASS_BIT  = 8;
  localparam int SEL9_BIT    = 9;
  localparam int SEL10_BIT   = 10;
  localparam int SCRUB_OFF_BIT = 11;
  localparam int ERR_SEL_BIT = 12;
  localparam int ADDR_W      = 19;
  localparam int DATA_W      = 32;
  localparam logic [3:0] RATE_RECOMMENDED  = 4'h7;  // about 111 kHz
  localparam logic [3:0] DELAY_RECOMMENDED = 4'hA;  // about 680 ns
  localparam logic [3:0] RATE_MIN_VALID    = 4'h4;  // codes below are not applicable

  // ********************************************************
  // host register port
  // ********************************************************
  localparam logic [1:0] REG_CTRL   = 2'h0;  // write: command, read: pending read and write flags
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_RDATA  = 2'h2;
  localparam logic [1:0] REG_CONFIG = 2'h3;  // control word to program
  localparam logic [12:0] CONFIG_RESET = {1'b0, 1'b0, 2'b00, 1'b0, DELAY_RECOMMENDED,
                                          RATE_RECOMMENDED};
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT  = 1;

  typedef enum logic [2:0] {
    SESC_IDLE    = 3'b000,
    SESC_SETUP   = 3'b001,
    SESC_FLAG_HI = 3'b011,
    SESC_CAPTURE = 3'b010,
    SESC_RELEASE = 3'b110
  } sesc_state_e;

  typedef struct packed {
    logic              chip_enable_one_n;
    logic              chip_enable_two;
    logic              output_enable_n;
    logic              write_enable_n;
    logic [ADDR_W-1:0] addr;
    logic              error_flag_o;
    logic              error_flag_oe;
  } sesc_pins_s;

  typedef struct packed {
    logic scrub_warning_n;
    logic scrub_active_n;
    logic error_flag_i;
  } sesc_sense_s;
endpackage

// ### logic/sesc_timer.sv
// module: loadable down counter used for the pin sequence delays
`timescale 1ns/10ps
module sesc_timer
  import sesc_pkg::*;
#(
  parameter int WIDTH = sesc_pkg::TIMER_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  done
);
  import sesc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } sesc_tmr_s;

  sesc_tmr_s state;
  sesc_tmr_s next_state;

  // a one-bit counter cannot hold the phase lengths
  if (WIDTH < 2) begin : g_bad_width
    $error("timer width too small");
  end

  // ********************************************************
  // counting
  // ********************************************************
  // done while zero; load wins over the decrement
  always_comb begin
    next_state = state;
    if (load) begin
      next_state.count = load_value;
    end else if (state.count != '0) begin
      next_state.count = state.count - 1'b1;
    end
  end

  assign done = (state.count == '0);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// ### logic/sesc_ctrl.sv
// module: host side controller that programs and reads back the scrub engine control word
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - control accesses drive address bits 10 and 9 low for a write.
// - power-up contents random; software writes then reads back to confirm.
// - reset config holds rate code 7 and delay code 10.
// - reset config holds bypass, scrub-off and error-select bits at zero.
// - no access started while scrub active is low.
module sesc_ctrl
  import sesc_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic [1:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic [31:0]               reg_rdata,
  output sesc_pkg::sesc_pins_s      pins,
  input  wire sesc_pkg::sesc_sense_s sense,
  input  wire logic [31:0]          data_in
);
  import sesc_pkg::*;

  typedef struct packed {
    sesc_state_e  fsm;
    logic         is_read;
    logic         pending_wr;
    logic         pending_rd;
    logic         busy;
    logic         configured;
    logic         done;
    logic [12:0]  config_word;
    logic [31:0]  read_word;
    logic [31:0]  rdata;
    sesc_pins_s   pins;
  } sesc_ctrl_s;

  sesc_ctrl_s state;
  sesc_ctrl_s next_state;

  logic                tmr_load;
  logic [TIMER_W-1:0]  tmr_value;
  logic                tmr_done;
  logic                link_free;
  logic [ADDR_W-1:0]   ctrl_addr;

  // flag stays up two cycles beyond the longer of the pulse width and the data-valid time
  localparam int FLAG_CYC = (FLAGH_CYC > DVALID_CYC) ? FLAGH_CYC : DVALID_CYC;

  // ********************************************************
  // elaboration checks
  // ********************************************************
  // a zero count would skip its phase, a count too large would wrap the timer
  if (SETUP_CYC < 1 || SETUP_CYC >= (1 << TIMER_W)) begin : g_bad_setup
    $error("setup count does not fit the timer");
  end
  if (FLAG_CYC < 1 || FLAG_CYC >= (1 << TIMER_W)) begin : g_bad_flag
    $error("flag count does not fit the timer");
  end
  if (RELEASE_CYC < 1 || RELEASE_CYC >= (1 << TIMER_W)) begin : g_bad_release
    $error("release count does not fit the timer");
  end

  sesc_timer #(
    .WIDTH      (TIMER_W)
  ) u_timer (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .load       (tmr_load),
    .load_value (tmr_value),
    .done       (tmr_done)
  );

  // ********************************************************
  // address pattern of a control access
  // ********************************************************
  // high bits forced low although ignored, so the bus never floats
  always_comb begin
    ctrl_addr = '0;
    ctrl_addr[DELAY_LSB+3:RATE_LSB] = state.config_word[7:0];
    ctrl_addr[BYPASS_BIT] = state.config_word[BYPASS_BIT];
    ctrl_addr[SCRUB_OFF_BIT] = state.config_word[SCRUB_OFF_BIT];
    ctrl_addr[ERR_SEL_BIT] = state.config_word[ERR_SEL_BIT];
    ctrl_addr[SEL10_BIT] = 1'b0;
    ctrl_addr[SEL9_BIT] = state.is_read;
  end

  // warning low is advance notice: hold off a fresh start until both pins rest high
  assign link_free = sense.scrub_active_n && sense.scrub_warning_n;

  // ********************************************************
  // sequencer
  // ********************************************************
  always_comb begin
    next_state = state;
    tmr_load   = 1'b0;
    tmr_value  = '0;
    next_state.done = 1'b0;
    // control word to program
    if (reg_write && reg_addr == REG_CONFIG) begin
      next_state.config_word = reg_wdata[12:0];
    end
    case (state.fsm)
      SESC_IDLE: begin
        next_state.pins.error_flag_oe = 1'b0;
        next_state.pins.chip_enable_one_n = 1'b1;
        next_state.pins.chip_enable_two = 1'b0;
        if (link_free && (state.pending_wr || state.pending_rd)) begin
          next_state.is_read = !state.pending_wr;
          next_state.busy = 1'b1;
          if (state.pending_wr) begin
            next_state.pending_wr = 1'b0;
          end else begin
            next_state.pending_rd = 1'b0;
          end
          next_state.fsm = SESC_SETUP;
          tmr_load = 1'b1;
          tmr_value = TIMER_W'(SETUP_CYC);
        end
      end
      SESC_SETUP: begin
        next_state.pins.chip_enable_one_n = 1'b0;
        next_state.pins.chip_enable_two = 1'b1;
        next_state.pins.output_enable_n = 1'b1;
        next_state.pins.write_enable_n = 1'b1;
        next_state.pins.addr = ctrl_addr;
        next_state.pins.error_flag_oe = 1'b1;
        next_state.pins.error_flag_o = 1'b0;
        if (tmr_done) begin
          next_state.pins.error_flag_o = 1'b1;
          next_state.fsm = SESC_FLAG_HI;
          tmr_load = 1'b1;
          tmr_value = TIMER_W'(FLAG_CYC);
        end
      end
      SESC_FLAG_HI: begin
        if (tmr_done) begin
          next_state.fsm = SESC_CAPTURE;
        end
      end
      SESC_CAPTURE: begin
        // data has been valid for longer than the flag-high-to-valid time
        if (state.is_read) begin
          next_state.read_word = data_in;
        end
        next_state.pins.error_flag_o = 1'b0;
        next_state.fsm = SESC_RELEASE;
        tmr_load = 1'b1;
        tmr_value = TIMER_W'(RELEASE_CYC);
      end
      SESC_RELEASE: begin
        // on a write, flag rising already released warning; wait before dropping enable
        if (tmr_done) begin
          next_state.pins.chip_enable_one_n = 1'b1;
          next_state.pins.chip_enable_two = 1'b0;
          next_state.pins.error_flag_oe = 1'b0;
          next_state.busy = 1'b0;
          next_state.done = 1'b1;
          if (!state.is_read) begin
            next_state.configured = 1'b1;
          end
          next_state.fsm = SESC_IDLE;
        end
      end
      default: begin
        next_state.fsm = SESC_IDLE;
      end
    endcase
    // commands ored in after the sequencer, so one landing with a start is never lost
    if (reg_write && reg_addr == REG_CTRL) begin
      next_state.pending_wr = next_state.pending_wr | reg_wdata[CMD_WRITE_BIT];
      next_state.pending_rd = next_state.pending_rd | reg_wdata[CMD_READ_BIT];
    end
    // read port, data one cycle later
    next_state.rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        REG_CTRL:   next_state.rdata = {30'h0, state.pending_rd, state.pending_wr};
        REG_STATUS: next_state.rdata = {25'h0,
                                        sense.error_flag_i && !state.pins.error_flag_oe,
                                        state.config_word[3:0] < RATE_MIN_VALID,
                                        !sense.scrub_active_n,
                                        !sense.scrub_warning_n,
                                        state.configured,
                                        state.done,
                                        state.busy};
        REG_RDATA:  next_state.rdata = state.read_word;
        default:    next_state.rdata = {19'h0, state.config_word};
      endcase
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= '0;
      state.fsm <= SESC_IDLE;
      state.config_word <= CONFIG_RESET;
      state.pins.chip_enable_one_n <= 1'b1;
      state.pins.output_enable_n <= 1'b1;
      state.pins.write_enable_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign pins = state.pins;
  assign reg_rdata = state.rdata;
endmodule

// ### sim/sesc_ctrl_properties.sv
// checker: pin sequence properties of the scrub controller
`timescale 1ns/10ps
module sesc_ctrl_properties
  import sesc_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic [1:0]            reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_write,
  input wire logic                  reg_read,
  input wire logic [31:0]           reg_rdata,
  input wire sesc_pkg::sesc_pins_s  pins,
  input wire sesc_pkg::sesc_sense_s sense,
  input wire logic [31:0]           data_in
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ********************************************************
  // control access framing
  // ********************************************************
  a_sel_bits_low : assert property (!pins.chip_enable_one_n |-> !pins.addr[SEL10_BIT])
    else $error("select bit high in access");
  a_enable_pair : assert property (pins.chip_enable_one_n != pins.chip_enable_two)
    else $error("enables disagree");
  a_strobes_high : assert property (!pins.chip_enable_one_n |->
    pins.output_enable_n && pins.write_enable_n)
    else $error("strobe low in access");
  a_flag_setup : assert property ($rose(pins.error_flag_o) |->
    $past(pins.error_flag_oe, 2) && $past(pins.chip_enable_one_n, 2) == 1'b0)
    else $error("flag rose without setup");
  a_flag_width : assert property ($rose(pins.error_flag_o) |->
    pins.error_flag_o [*4] ##1 !pins.error_flag_o)
    else $error("flag pulse width");
  a_release_order : assert property ($fell(pins.error_flag_o) |->
    !pins.chip_enable_one_n ##[1:5] pins.chip_enable_one_n)
    else $error("enable release order");
  // scrub in progress blocks new accesses; the start was decided two edges earlier
  a_no_start_scrub : assert property ($fell(pins.chip_enable_one_n) |->
    $past(sense.scrub_active_n, 2))
    else $error("access during scrub");
  a_defer_warning : assert property ($fell(pins.chip_enable_one_n) |->
    $past(sense.scrub_warning_n, 2))
    else $error("access after warning");
endmodule
bind sesc_ctrl sesc_ctrl_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .pins(pins), .sense(sense), .data_in(data_in));

// ### sim/sesc_mem_model.sv
// model: control register and scrub pin sequence of the memory device
`timescale 1ns/10ps
module sesc_mem_model
  import sesc_pkg::*;
(
  input  wire sesc_pkg::sesc_pins_s pins,
  input  wire logic                 scrub_req,
  output sesc_pkg::sesc_sense_s     sense,
  output logic [31:0]               data_in
);
  logic [12:0] ctrl   = 13'h1F5A;
  int          clash  = 0;
  logic        warn_n = 1'b1;
  logic        act_n  = 1'b1;
  // flag pin low when nobody drives it: no error reported
  assign sense = {warn_n, act_n, pins.error_flag_oe ? pins.error_flag_o : 1'b0};
  initial data_in = 32'h0;
  // control access is strobed by the rising error flag
  always @(posedge pins.error_flag_o) begin
    if (!pins.chip_enable_one_n && pins.chip_enable_two && !pins.addr[SEL10_BIT]) begin
      if (!pins.addr[SEL9_BIT]) begin
        ctrl = pins.addr[12:0];
        #15 warn_n = 1'b1;
      end else begin
        data_in <= #8 {19'h0, ctrl};
      end
    end
  end
  // released lines show the inverse so stale data never matches; deselect ends a scrub
  always @(posedge pins.chip_enable_one_n) begin
    data_in <= #4 ~data_in;
    #15 act_n = 1'b1;
    warn_n = 1'b1;
  end
  // memory is inaccessible while scrub is low; an access start requests a scrub
  always @(negedge pins.chip_enable_one_n) begin
    if (!act_n) clash++;
    #15 warn_n = 1'b0;
  end
  // scrub sequence; bypass or scrub-off suppresses it
  // one warning fall per request, never closer than a whole sequence
  always @(posedge scrub_req) begin
    if (!ctrl[8] && !ctrl[11]) begin
      #1 warn_n = 1'b0;
      #(80 + 60 * ctrl[7:4]) act_n = 1'b0;
      #250 act_n = 1'b1;
      #60 warn_n = 1'b1;
    end
  end
endmodule

// ### sim/sesc_ctrl_tb.sv
// testbench: register-level tests of the scrub controller against a device model
`timescale 1ns/10ps
module sesc_ctrl_tb;
  import sesc_pkg::*;
  logic        sys_clk     = 1'b0;
  logic        rst_n       = 1'b0;
  logic [1:0]  reg_addr    = 2'h0;
  logic [31:0] reg_wdata   = 32'h0;
  logic        reg_write   = 1'b0;
  logic        reg_read    = 1'b0;
  logic        scrub_req   = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] data_in;
  logic [31:0] val;
  sesc_pins_s  pins;
  sesc_sense_s sense;
  int          failures    = 0;
  int          check_count = 0;
  logic [12:0] cfg_list [3] = '{13'h1948, 13'h0003, 13'h00F4};

  sesc_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .pins(pins), .sense(sense), .data_in(data_in));
  sesc_mem_model u_mem (.pins(pins), .scrub_req(scrub_req), .sense(sense), .data_in(data_in));

  initial forever #5 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // bounded poll until nothing is pending or busy; pending first, so a queued
  // job has already raised busy when status is read
  task automatic wait_idle();
    int          n;
    logic [31:0] s;
    logic [31:0] p;
    for (n = 0; n < 100; n++) begin
      rd(REG_CTRL, p);
      rd(REG_STATUS, s);
      if (s[0] === 1'b0 && p[1:0] === 2'b00) break;
    end
    check(32'(n < 100), 32'h1);
  endtask

  // program, then read back in one command word
  task automatic prog(input logic [12:0] cfg);
    wr(REG_CONFIG, {19'h0, cfg});
    rd(REG_CONFIG, val);
    check(val, {19'h0, cfg});
    wr(REG_CTRL, 32'h3);
    wait_idle();
    check({19'h0, u_mem.ctrl}, {19'h0, cfg});
    rd(REG_RDATA, val);
    check(val, {19'h0, cfg});
    rd(REG_STATUS, val);
    check(32'({val[6], val[5], val[2]}), 32'({1'b0, cfg[3:0] < 4'h4, 1'b1}));
  endtask

  task automatic results();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #100000;
    failures++;
    results();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(REG_CONFIG, val);
    check(val, 32'h0000_00A7);
    rd(REG_STATUS, val);
    check(32'(val[2]), 32'h0);
    foreach (cfg_list[i]) prog(cfg_list[i]);
    prog(13'h00A7);
    // command issued while the warning is already low
    scrub_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wr(REG_CONFIG, 32'h0000_00A5);
    wr(REG_CTRL, 32'h1);
    scrub_req <= 1'b0;
    wait_idle();
    check(32'(u_mem.clash), 32'h0);
    check({19'h0, u_mem.ctrl}, 32'h0000_00A5);
    // read-back command alone returns the word just programmed
    wr(REG_CTRL, 32'h2);
    wait_idle();
    rd(REG_RDATA, val);
    check(val, 32'h0000_00A5);
    results();
  end
endmodule
